/* File: design/core_address_segment_router.sv */
`timescale 1ns/1ps
`default_nettype none

`include "segment_router_params.svh"

// What this block does
// - 32-bit address, top nibble picks segment
// - Absolute addressing reaches each segment's first 16KB
// - Top 16KB of segment two: core registers
// - No speculative access to segments 14, 15
// - Segment fifteen holds peripheral registers
// - Segments three to fifteen go to bus
// - Base plus displacement crossing segment traps
// - Data access to segments 0,1 stays local
// - Data access to segments 2-15 uses bus
// - Data access to core registers traps
// - Fetch local from 2, bus from 0,1
// - Fetch from segments 14, 15 traps
// - Fetch from core registers traps
// - Bus masters reach the whole space
// - Least significant byte at lowest address
// - Short loads sign or zero extended
// - Word alignment for address registers, else halfword
// - Fraction in upper half, lower half zero
// - True is one; non-zero tests true
// - Bus interface swaps bytes for big-endian
module core_address_segment_router
   import segment_router_pkg::*;
(
   input wire logic clk, // Core clock
   input wire logic reset, // Synchronous reset
   input wire logic ce, // Clock enable
   input wire logic ls_valid, // Load/store request
   input wire ls_req_t ls_req, // Load/store attributes
   input wire logic [31:0] ls_wdata, // Store data, right-justified
   input wire logic if_valid, // Fetch request
   input wire logic [31:0] if_addr, // Fetch address
   input wire logic sb_valid, // System bus master access
   input wire logic [31:0] sb_addr, // System bus address
   input wire logic ld_ret_valid, // Load data returned
   input wire logic [31:0] ld_ret_data, // Returned data, right-justified
   input wire logic bus_big_endian, // External partner is big-endian
   input wire logic [31:0] bool_in, // Value tested as boolean
   output decision_t ls_dec, // Load/store decision
   output logic ls_dec_valid, // Load/store decision strobe
   output logic [31:0] st_data_out, // Store data after byte order
   output decision_t if_dec, // Fetch decision
   output logic if_dec_valid, // Fetch decision strobe
   output target_t sb_target, // Resource hit by bus master
   output logic sb_target_valid, // Bus master decode strobe
   output logic [31:0] ld_result, // Load word for the register
   output logic ld_result_valid, // Load result strobe
   output logic trap_valid, // Trap to exception logic
   output trap_t trap_cause, // Reason of that trap
   output logic [31:0] bool_word // Boolean result, one or zero
);

   // ==========================================================
   // Load/store decode
   logic [31:0] ls_ea;
   logic [`SEG_W-1:0] ls_seg;
   logic ls_cross;
   logic ls_misalign;
   logic ls_core_regs;
   decision_t ls_next;

   // Segment bits moved to the top, gap zero filled
   assign ls_ea = ls_req.absolute ?
      {ls_req.abs_addr[`ABS_SEG_HI:`ABS_SEG_LO], `ABS_GAP,
       ls_req.abs_addr[`ABS_OFS_HI:0]} : ls_req.base + ls_req.disp;
   assign ls_seg = ls_ea[`SEG_HI:`SEG_LO];
   assign ls_cross = !ls_req.absolute &&
      (ls_req.base[`SEG_HI:`SEG_LO] != ls_seg);
   assign ls_misalign = ls_req.addr_reg ? (ls_ea[1:0] != 2'h0) :
      (ls_req.size != SZ_BYTE && ls_ea[0]);
   assign ls_core_regs = (ls_seg == `SEG_CODE) &&
      (ls_ea[`CORE_REGS_HI:`CORE_REGS_LO] == `CORE_REGS_TAG);

   always_comb
   begin
      ls_next.addr = ls_ea;
      // Default: out on the system bus
      ls_next.route = ROUTE_BUS;
      ls_next.trap = TRAP_NONE;
      ls_next.target = TGT_SYSTEM;
      if (ls_cross)
      begin
         ls_next.route = ROUTE_TRAP;
         ls_next.trap = TRAP_SEG_CROSS;
         ls_next.target = TGT_NONE;
      end
      else if (ls_misalign)
      begin
         ls_next.route = ROUTE_TRAP;
         ls_next.trap = TRAP_ALIGN;
         ls_next.target = TGT_NONE;
      end
      // Data access to core registers refused
      else if (ls_core_regs)
      begin
         ls_next.route = ROUTE_TRAP;
         ls_next.trap = TRAP_CORE_REGS_DATA;
         ls_next.target = TGT_NONE;
      end
      // Local data memory, no bus cycle
      else if (ls_seg <= `SEG_DYNAMIC_DATA)
      begin
         ls_next.route = ROUTE_LOCAL;
         ls_next.target = TGT_DATA_MEM;
      end
      else if (ls_req.spec && ls_seg >= `SEG_NO_SPEC_LO)
      begin
         ls_next.route = ROUTE_DEFER;
         ls_next.target = TGT_NONE;
      end
      // Code constants reached over the bus
      else if (ls_seg == `SEG_CODE)
         ls_next.target = TGT_CODE_MEM;
      else if (ls_seg == `SEG_PERIPH)
         ls_next.target = TGT_PERIPH;
   end

   // ==========================================================
   // Fetch decode
   logic [`SEG_W-1:0] if_seg;
   decision_t if_next;

   assign if_seg = if_addr[`SEG_HI:`SEG_LO];

   always_comb
   begin
      if_next.addr = if_addr;
      if_next.route = ROUTE_BUS;
      if_next.trap = TRAP_NONE;
      if_next.target = TGT_SYSTEM;
      if (if_seg == `SEG_CODE &&
          if_addr[`CORE_REGS_HI:`CORE_REGS_LO] == `CORE_REGS_TAG)
      begin
         if_next.route = ROUTE_TRAP;
         if_next.trap = TRAP_CORE_REGS_FETCH;
         if_next.target = TGT_NONE;
      end
      // No fetch from top two segments
      else if (if_seg >= `SEG_NO_SPEC_LO)
      begin
         if_next.route = ROUTE_TRAP;
         if_next.trap = TRAP_FETCH_SEG;
         if_next.target = TGT_NONE;
      end
      // Local code, data memory via bus
      else if (if_seg == `SEG_CODE)
      begin
         if_next.route = ROUTE_LOCAL;
         if_next.target = TGT_CODE_MEM;
      end
      else if (if_seg <= `SEG_DYNAMIC_DATA)
         if_next.target = TGT_DATA_MEM;
   end

   // ==========================================================
   // System bus master decode
   target_t sb_next;

   // Whole space visible to bus masters
   always_comb
   begin
      case (sb_addr[`SEG_HI:`SEG_LO])
         `SEG_STATIC_DATA, `SEG_DYNAMIC_DATA: sb_next = TGT_DATA_MEM;
         `SEG_CODE:
         begin
            if (sb_addr[`CORE_REGS_HI:`CORE_REGS_LO] == `CORE_REGS_TAG)
               sb_next = TGT_CORE_REGS;
            else
               sb_next = TGT_CODE_MEM;
         end
         `SEG_PERIPH: sb_next = TGT_PERIPH;
         default: sb_next = TGT_SYSTEM;
      endcase
   end

   // ==========================================================
   // Decision registers
   // One registered decision per access
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         ls_dec <= '{route: ROUTE_LOCAL, trap: TRAP_NONE, target: TGT_NONE,
                     addr: `RST_WORD};
         ls_dec_valid <= 1'b0;
      end
      else if (ce)
      begin
         ls_dec_valid <= ls_valid;
         if (ls_valid)
            ls_dec <= ls_next;
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         if_dec <= '{route: ROUTE_LOCAL, trap: TRAP_NONE, target: TGT_NONE,
                     addr: `RST_WORD};
         if_dec_valid <= 1'b0;
      end
      else if (ce)
      begin
         if_dec_valid <= if_valid;
         if (if_valid)
            if_dec <= if_next;
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         sb_target <= TGT_NONE;
         sb_target_valid <= 1'b0;
      end
      else if (ce)
      begin
         sb_target_valid <= sb_valid;
         if (sb_valid)
            sb_target <= sb_next;
      end
   end

   // Trap cause to exception logic, load/store first
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         trap_valid <= 1'b0;
         trap_cause <= TRAP_NONE;
      end
      else if (ce)
      begin
         trap_valid <= (ls_valid && ls_next.route == ROUTE_TRAP) ||
            (if_valid && if_next.route == ROUTE_TRAP);
         if (ls_valid && ls_next.route == ROUTE_TRAP)
            trap_cause <= ls_next.trap;
         else if (if_valid && if_next.route == ROUTE_TRAP)
            trap_cause <= if_next.trap;
         else
            trap_cause <= TRAP_NONE;
      end
   end

   // ==========================================================
   // Data shaping
   logic pend_bus;
   size_t pend_size;
   logic pend_sign;
   logic pend_frac;
   logic [31:0] ld_shaped;
   logic [31:0] st_shaped;

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         pend_bus <= 1'b0;
         pend_size <= SZ_WORD;
         pend_sign <= 1'b0;
         pend_frac <= 1'b0;
      end
      else if (ce && ls_valid && !ls_req.write && ls_next.route != ROUTE_TRAP)
      begin
         pend_bus <= (ls_next.route != ROUTE_LOCAL);
         pend_size <= ls_req.size;
         pend_sign <= ls_req.sign_ext;
         pend_frac <= ls_req.frac;
      end
   end

   // Little-endian unless the bus partner is big-endian
   load_format u_load_format (
      .raw(ld_ret_data),
      .size(pend_size),
      .sign_ext(pend_sign),
      .frac(pend_frac),
      .swap(pend_bus && bus_big_endian),
      .word(ld_shaped)
   );

   load_format u_store_format (
      .raw(ls_wdata),
      .size(ls_req.size),
      .sign_ext(1'b0),
      .frac(1'b0),
      .swap(ls_next.route == ROUTE_BUS && bus_big_endian),
      .word(st_shaped)
   );

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         ld_result <= `RST_WORD;
         ld_result_valid <= 1'b0;
         st_data_out <= `RST_WORD;
      end
      else if (ce)
      begin
         ld_result_valid <= ld_ret_valid;
         if (ld_ret_valid)
            ld_result <= ld_shaped;
         if (ls_valid && ls_req.write)
            st_data_out <= st_shaped;
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
         bool_word <= `BOOL_FALSE;
      else if (ce)
         bool_word <= (bool_in != `RST_WORD) ? `BOOL_TRUE : `BOOL_FALSE;
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   sequence s_ls_ok;
      ce && ls_valid && !ls_cross && !ls_misalign && !ls_core_regs;
   endsequence

   sequence s_frac_return;
      ce && ld_ret_valid && pend_frac && pend_size == SZ_HALF;
   endsequence

   a_seg_cross_trap: assert property (
      ce && ls_valid && ls_cross |=> ls_dec.route == ROUTE_TRAP &&
         trap_valid && trap_cause == TRAP_SEG_CROSS)
      else $error("segment crossing did not trap");

   a_align_trap: assert property (
      ce && ls_valid && !ls_cross && ls_misalign |=>
         ls_dec.trap == TRAP_ALIGN && trap_valid)
      else $error("misaligned access did not trap");

   a_local_data_route: assert property (
      s_ls_ok ##0 (ls_seg <= `SEG_DYNAMIC_DATA) |=>
         ls_dec_valid && ls_dec.route == ROUTE_LOCAL && ls_dec.addr == $past(ls_ea))
      else $error("local data access left the core");

   a_no_spec_high: assert property (
      s_ls_ok ##0 (ls_req.spec && ls_seg >= `SEG_NO_SPEC_LO) |=>
         ls_dec.route == ROUTE_DEFER && (!trap_valid || $past(if_valid)))
      else $error("speculative access to top segments issued");

   a_core_regs_data: assert property (
      ce && ls_valid && !ls_cross && !ls_misalign && ls_core_regs |=>
         ls_dec.route == ROUTE_TRAP && trap_cause == TRAP_CORE_REGS_DATA)
      else $error("data access to core registers not refused");

   a_fetch_high_trap: assert property (
      ce && if_valid && if_seg >= `SEG_NO_SPEC_LO |=>
         if_dec_valid && if_dec.trap == TRAP_FETCH_SEG && trap_valid)
      else $error("fetch from top segments not refused");

   a_fetch_code_local: assert property (
      ce && if_valid && if_seg == `SEG_CODE &&
      if_addr[`CORE_REGS_HI:`CORE_REGS_LO] != `CORE_REGS_TAG |=>
         if_dec.route == ROUTE_LOCAL && if_dec.target == TGT_CODE_MEM)
      else $error("code fetch not served locally");

   a_fetch_core_regs: assert property (
      ce && if_valid && if_seg == `SEG_CODE &&
      if_addr[`CORE_REGS_HI:`CORE_REGS_LO] == `CORE_REGS_TAG |=>
         if_dec.trap == TRAP_CORE_REGS_FETCH)
      else $error("fetch from core registers not refused");

   a_frac_low_zero: assert property (
      s_frac_return |=> ld_result_valid && ld_result[15:0] == `HALF_ZERO)
      else $error("fraction lower half not cleared");

   a_bool_one_zero: assert property (
      ce ##1 1'b1 |-> bool_word == (($past(bool_in) != `RST_WORD) ?
         `BOOL_TRUE : `BOOL_FALSE))
      else $error("boolean result not one or zero");

endmodule

`default_nettype wire

/* File: design/load_format.sv */
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Byte order and width shaping of one data word
module load_format
   import segment_router_pkg::*;
(
   input wire logic [31:0] raw, // Right-justified data
   input wire size_t size, // Access width
   input wire logic sign_ext, // Sign rather than zero fill
   input wire logic frac, // Halfword is a signed fraction
   input wire logic swap, // Partner is big-endian
   output logic [31:0] word // Shaped register word
);

   logic [31:0] ordered;

   for (genvar i = 0; i < 4; i++)
   begin : g_lane
      if (i < 2)
      begin : g_low
         assign ordered[8*i +: 8] = !swap ? raw[8*i +: 8] :
            (size == SZ_WORD) ? raw[8*(3-i) +: 8] :
            (size == SZ_HALF) ? raw[8*(1-i) +: 8] : raw[8*i +: 8];
      end
      else
      begin : g_high
         assign ordered[8*i +: 8] = (swap && size == SZ_WORD) ?
            raw[8*(3-i) +: 8] : raw[8*i +: 8];
      end
   end

   always_comb
   begin
      case (size)
         SZ_BYTE: word = {{24{sign_ext & ordered[7]}}, ordered[7:0]};
         SZ_HALF:
         begin
            if (frac)
               word = {ordered[15:0], `HALF_ZERO};
            else
               word = {{16{sign_ext & ordered[15]}}, ordered[15:0]};
         end
         default: word = ordered;
      endcase
   end

endmodule

`default_nettype wire

/* File: design/segment_router_params.svh */
`ifndef SEGMENT_ROUTER_PARAMS_SVH
`define SEGMENT_ROUTER_PARAMS_SVH

// ==========================================================
// Segment field of a 32-bit address
`define SEG_HI 31
`define SEG_LO 28
`define SEG_W 4

// ==========================================================
// Segment numbers
`define SEG_STATIC_DATA 4'h0
`define SEG_DYNAMIC_DATA 4'h1
`define SEG_CODE 4'h2
`define SEG_NO_SPEC_LO 4'he
`define SEG_PERIPH 4'hf

// ==========================================================
// Core register window: top 16 KB of the code segment
`define CORE_REGS_LO 14
`define CORE_REGS_HI 27
`define CORE_REGS_TAG 14'h3fff

// ==========================================================
// Absolute address layout (18-bit constant)
`define ABS_SEG_HI 17
`define ABS_SEG_LO 14
`define ABS_OFS_HI 13
`define ABS_GAP 14'h0000

// ==========================================================
// Reset values, boolean words and fraction fill
`define RST_WORD 32'h0000_0000
`define BOOL_TRUE 32'h0000_0001
`define BOOL_FALSE 32'h0000_0000
`define HALF_ZERO 16'h0000

`endif

/* File: design/segment_router_pkg.sv */
package segment_router_pkg;

   typedef enum logic [1:0] {
      SZ_BYTE = 2'b00,
      SZ_HALF = 2'b01,
      SZ_WORD = 2'b10
   } size_t;

   typedef enum logic [1:0] {
      ROUTE_LOCAL = 2'b00,
      ROUTE_BUS = 2'b01,
      ROUTE_TRAP = 2'b10,
      ROUTE_DEFER = 2'b11
   } route_t;

   typedef enum logic [2:0] {
      TRAP_NONE = 3'b000,
      TRAP_SEG_CROSS = 3'b001,
      TRAP_ALIGN = 3'b010,
      TRAP_CORE_REGS_DATA = 3'b011,
      TRAP_FETCH_SEG = 3'b100,
      TRAP_CORE_REGS_FETCH = 3'b101
   } trap_t;

   typedef enum logic [2:0] {
      TGT_NONE = 3'b000,
      TGT_DATA_MEM = 3'b001,
      TGT_CODE_MEM = 3'b010,
      TGT_CORE_REGS = 3'b011,
      TGT_PERIPH = 3'b100,
      TGT_SYSTEM = 3'b101
   } target_t;

   typedef struct packed {
      logic [31:0] base;
      logic [31:0] disp;
      logic absolute;
      logic [17:0] abs_addr;
      logic write;
      size_t size;
      logic addr_reg;
      logic sign_ext;
      logic frac;
      logic spec;
   } ls_req_t;

   typedef struct packed {
      route_t route;
      trap_t trap;
      target_t target;
      logic [31:0] addr;
   } decision_t;

endpackage

/* File: testbench/far_side_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ==========================================
// Memory side answering local and bus reads
module far_side_model
   import segment_router_pkg::*;
(
   input wire logic clk, // Core clock
   input wire logic reset, // Synchronous reset
   input wire logic dec_valid, // Decision strobe
   input wire decision_t dec, // Decision of the access
   input wire logic rd, // Accesses in flight are reads
   input wire logic [31:0] word, // Data to return
   input wire logic [3:0] delay, // Wait before answering
   output logic ret_valid, // Data strobe
   output logic [31:0] ret_data // Returned data
);
   logic busy;
   logic [3:0] cnt;
   logic [31:0] hold;

   always @(posedge clk)
   begin
      if (reset)
      begin
         busy <= 1'b0;
         ret_valid <= 1'b0;
         ret_data <= 32'h0000_0000;
      end
      else
      begin
         ret_valid <= 1'b0;
         // Released lines carry the inverted previous value
         ret_data <= ~ret_data;
         if (busy && cnt == 4'h0)
         begin
            ret_valid <= 1'b1;
            ret_data <= hold;
            busy <= 1'b0;
         end
         else if (busy)
            cnt <= cnt - 4'h1;
         else if (dec_valid && rd && (dec.route == ROUTE_LOCAL || dec.route == ROUTE_BUS))
         begin
            busy <= 1'b1;
            cnt <= delay;
            hold <= word;
         end
      end
   end
endmodule

`default_nettype wire

/* File: testbench/test_core_address_segment_router.sv */
`timescale 1ns/1ps
`default_nettype none

`define CHK(g, e) begin logic [63:0] gv, ev; gv = 64'(g); ev = 64'(e); total_checks++; \
   if (gv !== ev) begin error_cnt++; \
   $display("MISMATCH t=%0t got %h exp %h", $time, gv, ev); end end

module test_core_address_segment_router
   import segment_router_pkg::*;
;
   typedef struct packed {
      decision_t d;
      logic full;
      logic st;
      logic [31:0] sd;
   } ls_note_t;

   logic clk = 1'b0, reset = 1'b1, ce = 1'b1, big = 1'b0, rd = 1'b0;
   logic ls_valid = 1'b0, if_valid = 1'b0, sb_valid = 1'b0, ls_trapped = 1'b0;
   ls_req_t ls_req = '0, r;
   logic [31:0] ls_wdata = 32'h0000_0000, if_addr = 32'h0000_0000;
   logic [31:0] sb_addr = 32'h0000_0000, bool_in = 32'h0000_0000;
   logic [31:0] ret_word = 32'h0000_0000, raw;
   logic [3:0] ret_delay = 4'h0, dly;
   decision_t ls_dec, if_dec, fd;
   target_t sb_target;
   trap_t trap_cause;
   logic ls_dec_valid, if_dec_valid, sb_target_valid, ld_result_valid, trap_valid;
   logic ld_ret_valid;
   logic [31:0] st_data_out, ld_result, bool_word, ld_ret_data;
   ls_note_t ls_q[$], n;
   decision_t if_q[$];
   target_t sb_q[$];
   logic [31:0] ld_q[$];
   trap_t tr_q[$];
   int error_cnt = 0, total_checks = 0, cyc = 0;
   logic [31:0] cb[9] = '{32'h0fff_fffc, 32'h1000_0000, 32'h3000_0000, 32'h3000_0000,
      32'h3000_0000, 32'h3000_0000, 32'h2fff_c000, 32'h2fff_bffc, 32'h2fff_c000};
   logic [31:0] cd[9] = '{32'h0000_0008, 32'hffff_fffc, 32'h0000_0002, 32'h0000_0001,
      32'h0000_0001, 32'h0000_0002, 32'h0000_0000, 32'h0000_0000, 32'h0000_0001};
   logic [2:0] cf[9] = '{3'b010, 3'b010, 3'b110, 3'b001, 3'b000, 3'b010, 3'b010, 3'b010,
      3'b001};

   always #2.5 clk = ~clk;

   core_address_segment_router u_core_address_segment_router (.clk(clk), .reset(reset),
      .ce(ce), .ls_valid(ls_valid), .ls_req(ls_req), .ls_wdata(ls_wdata),
      .if_valid(if_valid), .if_addr(if_addr), .sb_valid(sb_valid), .sb_addr(sb_addr),
      .ld_ret_valid(ld_ret_valid), .ld_ret_data(ld_ret_data), .bus_big_endian(big),
      .bool_in(bool_in), .ls_dec(ls_dec), .ls_dec_valid(ls_dec_valid),
      .st_data_out(st_data_out), .if_dec(if_dec), .if_dec_valid(if_dec_valid),
      .sb_target(sb_target), .sb_target_valid(sb_target_valid), .ld_result(ld_result),
      .ld_result_valid(ld_result_valid), .trap_valid(trap_valid),
      .trap_cause(trap_cause), .bool_word(bool_word));

   far_side_model u_far_side_model (.clk(clk), .reset(reset), .dec_valid(ls_dec_valid),
      .dec(ls_dec), .rd(rd), .word(ret_word), .delay(ret_delay),
      .ret_valid(ld_ret_valid), .ret_data(ld_ret_data));

   // ==========================================
   // Expected values
   function automatic logic [31:0] shape(logic [31:0] v, size_t z, logic sx, logic fr);
      case (z)
         SZ_BYTE: return sx ? {{24{v[7]}}, v[7:0]} : {24'h00_0000, v[7:0]};
         SZ_HALF: return fr ? {v[15:0], 16'h0000} : sx ? {{16{v[15]}}, v[15:0]} :
            {16'h0000, v[15:0]};
         default: return v;
      endcase
   endfunction

   function automatic logic [31:0] swap(logic [31:0] v, size_t z);
      return z == SZ_WORD ? {v[7:0], v[15:8], v[23:16], v[31:24]} :
         z == SZ_HALF ? {16'h0000, v[7:0], v[15:8]} : v;
   endfunction

   function automatic decision_t ls_expect(ls_req_t q);
      decision_t d;
      logic [3:0] s;
      d.addr = q.absolute ? {q.abs_addr[17:14], 14'h0000, q.abs_addr[13:0]} : q.base + q.disp;
      s = d.addr[31:28];
      d.trap = TRAP_NONE;
      if (!q.absolute && s != q.base[31:28])
         d.trap = TRAP_SEG_CROSS;
      else if (q.addr_reg ? d.addr[1:0] != 2'b00 : q.size != SZ_BYTE && d.addr[0])
         d.trap = TRAP_ALIGN;
      else if (s == 4'h2 && d.addr[27:14] == 14'h3fff)
         d.trap = TRAP_CORE_REGS_DATA;
      d.route = d.trap != TRAP_NONE ? ROUTE_TRAP : q.spec && s >= 4'he ? ROUTE_DEFER :
         s < 4'h2 ? ROUTE_LOCAL : ROUTE_BUS;
      d.target = s < 4'h2 ? TGT_DATA_MEM : s == 4'h2 ? TGT_CODE_MEM :
         s == 4'hf ? TGT_PERIPH : TGT_SYSTEM;
      return d;
   endfunction

   // ==========================================
   // Drivers
   task automatic ls_put(input ls_req_t q, input logic [31:0] wd);
      n.d = ls_expect(q);
      n.full = n.d.route == ROUTE_LOCAL || n.d.route == ROUTE_BUS;
      n.st = q.write && n.full;
      n.sd = shape(wd, q.size, 1'b0, 1'b0);
      if (n.d.route == ROUTE_BUS && big)
         n.sd = swap(n.sd, q.size);
      ls_q.push_back(n);
      if (n.d.route == ROUTE_TRAP)
      begin
         tr_q.push_back(n.d.trap);
         ls_trapped = 1'b1;
      end
      if (!q.write && n.full)
         ld_q.push_back(shape((n.d.route == ROUTE_BUS && big) ? swap(wd, q.size) : wd,
            q.size, q.sign_ext, q.frac));
      ls_req <= q;
      ls_wdata <= wd;
   endtask

   task automatic if_put(input logic [31:0] a);
      decision_t d;
      logic [3:0] s;
      s = a[31:28];
      d.addr = a;
      d.trap = s == 4'h2 && a[27:14] == 14'h3fff ? TRAP_CORE_REGS_FETCH :
         s >= 4'he ? TRAP_FETCH_SEG : TRAP_NONE;
      d.route = d.trap != TRAP_NONE ? ROUTE_TRAP : s == 4'h2 ? ROUTE_LOCAL : ROUTE_BUS;
      d.target = s == 4'h2 ? TGT_CODE_MEM : s < 4'h2 ? TGT_DATA_MEM : TGT_SYSTEM;
      if_q.push_back(d);
      if (d.route == ROUTE_TRAP && !ls_trapped)
         tr_q.push_back(d.trap);
      if_addr <= a;
   endtask

   task automatic sb_put(input logic [31:0] a);
      sb_q.push_back(a[31:28] < 4'h2 ? TGT_DATA_MEM : a[31:28] == 4'hf ? TGT_PERIPH :
         a[31:28] != 4'h2 ? TGT_SYSTEM : a[27:14] == 14'h3fff ? TGT_CORE_REGS : TGT_CODE_MEM);
      sb_addr <= a;
   endtask

   task automatic fire(input logic l, input logic i, input logic s);
      ls_valid <= l;
      if_valid <= i;
      sb_valid <= s;
      ls_trapped = 1'b0;
      @(posedge clk);
   endtask

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // ==========================================
   // Output watcher
   always @(negedge clk)
   begin
      if (!reset && ls_dec_valid)
      begin
         `CHK(ls_q.size() > 0, 1'b1)
         n = ls_q.pop_front();
         `CHK(ls_dec.route, n.d.route)
         `CHK(ls_dec.trap, n.d.trap)
         if (n.full) `CHK({ls_dec.target, ls_dec.addr}, {n.d.target, n.d.addr})
         if (n.st) `CHK(st_data_out, n.sd)
      end
      if (!reset && if_dec_valid)
      begin
         `CHK(if_q.size() > 0, 1'b1)
         fd = if_q.pop_front();
         `CHK({if_dec.route, if_dec.trap}, {fd.route, fd.trap})
         if (fd.route != ROUTE_TRAP)
            `CHK({if_dec.target, if_dec.addr}, {fd.target, fd.addr})
      end
      if (!reset && sb_target_valid)
         `CHK(sb_target, sb_q.pop_front())
      if (!reset && ld_result_valid)
         `CHK(ld_result, ld_q.pop_front())
      if (!reset && trap_valid)
         `CHK(trap_cause, tr_q.pop_front())
   end

   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         error_cnt++;
         wrap_up();
      end
   end

   // ==========================================
   // Scenarios
   initial
   begin
      void'($urandom(55040));
      repeat (20) @(posedge clk);
      reset <= 1'b0;
      @(negedge clk);
      `CHK({ls_dec_valid, trap_valid, trap_cause}, {2'b00, TRAP_NONE})
      `CHK(bool_word, 32'h0000_0000)
      @(posedge clk);
      for (int e = 0; e < 2; e++)
      begin
         big <= e[0];
         fire(1'b0, 1'b0, 1'b0);
         for (int s = 0; s < 16; s++)
         begin
            r = '0;
            r.base = {s[3:0], 28'h000_0100};
            r.disp = 32'h0000_0010;
            r.write = 1'b1;
            r.size = size_t'($urandom_range(0, 2));
            ls_put(r, $urandom());
            fire(1'b1, 1'b0, 1'b0);
         end
      end
      $display("segment sweep done");
      for (int i = 0; i < 9; i++)
      begin
         r = '0;
         r.base = cb[i];
         r.disp = cd[i];
         r.size = size_t'(cf[i][1:0]);
         r.addr_reg = cf[i][2];
         r.write = 1'b1;
         ls_put(r, $urandom());
         if_put(32'hf000_0000);
         fire(1'b1, 1'b1, 1'b0);
      end
      $display("corner cases done");
      for (int i = 0; i < 32; i++)
      begin
         r = '0;
         r.absolute = 1'b1;
         r.base = $urandom();
         r.abs_addr = {i[4:1], 14'($urandom())};
         r.spec = i[0];
         r.write = 1'b1;
         ls_put(r, $urandom());
         fire(1'b1, 1'b0, 1'b0);
      end
      $display("absolute and speculative done");
      for (int i = 0; i < 18; i++)
      begin
         raw = i < 16 ? {i[3:0], 14'($urandom()), 14'h0000} : {28'h2ff_ffff, 1'b1, i[0], 2'b00};
         if_put({raw[31:2], 2'b00});
         sb_put(raw);
         fire(1'b0, 1'b1, 1'b1);
      end
      if_put(32'h2fff_bffc);
      sb_put(32'h2fff_bffc);
      fire(1'b0, 1'b1, 1'b1);
      $display("fetch and bus master done");
      rd <= 1'b1;
      for (int i = 0; i < 24; i++)
      begin
         big <= i[3];
         raw = $urandom();
         dly = 4'($urandom_range(0, 3));
         ret_word <= raw;
         ret_delay <= dly;
         fire(1'b0, 1'b0, 1'b0);
         r = '0;
         r.base = i[2] ? 32'h3000_0040 : 32'h0000_0040;
         r.size = size_t'(i % 3);
         r.sign_ext = i[0];
         r.frac = i[1] && r.size == SZ_HALF;
         ls_put(r, raw);
         fire(1'b1, 1'b0, 1'b0);
         repeat (dly + 5) fire(1'b0, 1'b0, 1'b0);
      end
      rd <= 1'b0;
      $display("load shaping done");
      for (int i = 0; i < 40; i++)
      begin
         r = '0;
         r.base = {4'($urandom()), 20'hf_ffff, 8'($urandom())};
         r.disp = 32'($urandom_range(0, 511)) - 32'h0000_0100;
         r.size = size_t'($urandom_range(0, 2));
         r.addr_reg = r.size == SZ_WORD && $urandom_range(0, 1);
         r.spec = 1'($urandom());
         r.write = 1'b1;
         ls_put(r, $urandom());
         fire(1'b1, 1'b0, 1'b0);
      end
      fire(1'b0, 1'b0, 1'b0);
      $display("random traffic done");
      for (int i = 0; i < 4; i++)
      begin
         // Last pass: clock enable low, result must hold
         raw = i == 1 ? 32'h8000_0000 : i == 2 ? $urandom() | 32'h0000_0001 : 32'h0000_0000;
         bool_in <= raw;
         ce <= i != 3;
         @(posedge clk);
         @(negedge clk);
         `CHK(bool_word, {31'h0000_0000, i != 0})
         @(posedge clk);
      end
      ce <= 1'b1;
      $display("boolean done");
      repeat (10) fire(1'b0, 1'b0, 1'b0);
      `CHK(ls_q.size() + if_q.size() + sb_q.size() + ld_q.size() + tr_q.size(), 0)
      wrap_up();
   end
endmodule

`default_nettype wire
